/* include/sct_pkg.sv */
`default_nettype none

package sct_pkg;

	// Clock, resolution and counter width
	localparam int SCT_CLK_NS   = 4;
	localparam int SCT_RES_BITS = 18;
	localparam int SCT_CNT_W    = 8;

	// Least time rounds up to whole cycles
	function automatic int sct_ceil_cyc(input int ns);
		int c;
		c = (ns + SCT_CLK_NS - 1) / SCT_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Longest time rounds down, never below one cycle
	function automatic int sct_floor_cyc(input int ns);
		int c;
		c = ns / SCT_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Times as specified, in ns
	localparam int SCT_FAST_CONV_NS    = 340;
	localparam int SCT_NORM_CONV_NS    = 465;
	localparam int SCT_BUSY_DLY_NS     = 30;
	localparam int SCT_EOC_BUSY_NS     = 10;
	localparam int SCT_DATA_LEAD_NS    = 20;
	localparam int SCT_FAST_SPACING_NS = 500;
	localparam int SCT_NORM_SPACING_NS = 667;
	localparam int SCT_FAST_ACQ_NS     = 70;
	localparam int SCT_NORM_ACQ_NS     = 100;
	localparam int SCT_FAST_MAX_GAP_NS = 1000000;

	// Derived cycle counts
	localparam int SCT_FAST_CONV_CYC    = sct_floor_cyc(SCT_FAST_CONV_NS);
	localparam int SCT_NORM_CONV_CYC    = sct_floor_cyc(SCT_NORM_CONV_NS);
	localparam int SCT_BUSY_DLY_CYC     = sct_floor_cyc(SCT_BUSY_DLY_NS);
	localparam int SCT_EOC_BUSY_CYC     = sct_ceil_cyc(SCT_EOC_BUSY_NS);
	localparam int SCT_DATA_LEAD_CYC    = sct_ceil_cyc(SCT_DATA_LEAD_NS);
	localparam int SCT_TAIL_CYC         = (SCT_EOC_BUSY_CYC > SCT_DATA_LEAD_CYC) ?
		SCT_EOC_BUSY_CYC : SCT_DATA_LEAD_CYC;
	localparam int SCT_FAST_SPACING_CYC = sct_ceil_cyc(SCT_FAST_SPACING_NS);
	localparam int SCT_NORM_SPACING_CYC = sct_ceil_cyc(SCT_NORM_SPACING_NS);
	localparam int SCT_FAST_ACQ_CYC     = sct_ceil_cyc(SCT_FAST_ACQ_NS);
	localparam int SCT_NORM_ACQ_CYC     = sct_ceil_cyc(SCT_NORM_ACQ_NS);
	localparam int SCT_FAST_MAX_GAP_CYC = sct_floor_cyc(SCT_FAST_MAX_GAP_NS);

	// Values after reset
	localparam logic [SCT_RES_BITS-1:0] SCT_DATA_RST = 18'h00000;

	typedef enum logic [1:0] {
		SCT_IDLE,
		SCT_CONV,
		SCT_TAIL
	} sct_state_t;

	// Result as seen by the controller
	typedef struct packed {
		logic [SCT_RES_BITS-1:0] data;
		logic                    valid;
	} sct_result_t;

	// Observed controller timing faults, one-cycle pulses
	typedef struct packed {
		logic overrun;
		logic early;
		logic stale;
	} sct_fault_t;

endpackage

`default_nettype wire

/* test/sar_conversion_timing_tb.sv */
`default_nettype none

module sar_conversion_timing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk = 1'b0;
	logic                 arst_n = 1'b0;
	logic                 cs_n;
	logic                 fast;
	logic                 busy;
	logic [17:0]          smp;
	sct_pkg::sct_result_t res;
	sct_pkg::sct_fault_t  flt;
	int                   n_errors = 0;
	int                   checks_done = 0;
	int                   n_ovr = 0;
	int                   n_early = 0;
	int                   n_stale = 0;

	always #2 clk = ~clk;

	// Fault pulses last one cycle, so tally them at every falling edge, where they are settled
	always @(negedge clk) begin
		if (flt.overrun === 1'b1) n_ovr++;
		if (flt.early === 1'b1) n_early++;
		if (flt.stale === 1'b1) n_stale++;
	end

	sct_core #(.MAX_GAP_CYC(300)) u_dut (.clk_in(clk), .arst_n_in(arst_n),
		.convert_start_n_in(cs_n), .fast_mode_in(fast), .sample_in(smp),
		.busy_out(busy), .result_out(res), .fault_out(flt));
	sct_host u_host (.clk_in(clk), .busy_in(busy), .res_in(res),
		.convert_start_n_out(cs_n), .fast_out(fast), .smp_out(smp));

	task automatic wrap_up;
		if (n_errors == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk_d(input logic [17:0] g, input logic [17:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %0t value %h not %h", $time, g, e);
		end
	endtask

	task automatic chk_le(input int a, input int b);
		checks_done++;
		if (a > b) begin
			n_errors++;
			$display("mismatch %0t bound %0d above %0d", $time, a, b);
		end
	endtask

	// Run one conversion and judge its timing and result
	task automatic run(input logic f, input logic [17:0] v, input logic r, input logic p);
		logic [17:0] got;
		int nb;
		int tv;
		int lim;
		lim = (f ? sct_pkg::SCT_FAST_CONV_NS : sct_pkg::SCT_NORM_CONV_NS) / sct_pkg::SCT_CLK_NS;
		u_host.conv(f, v, r, p, got, nb, tv);
		chk_le(1, nb);
		chk_le(1, tv);
		chk_le(tv, lim);
		chk_le(nb + 1, lim);
		chk_le(5, nb + 1 - tv);
		chk_d(got, v);
		if (nb >= 199) wrap_up();
	endtask

	task automatic sc_reset;
		chk_d(res.data, 18'h00000);
		chk_d(18'({busy, res.valid, flt}), 18'h00000);
	endtask

	// Legal back-to-back at minimum spacing, extreme codes, mode change
	task automatic sc_b2b;
		int n;
		n = n_early;
		run(1'b1, 18'h3FFFF, 1'b0, 1'b0);
		run(1'b1, 18'h00000, 1'b0, 1'b0);
		run(1'b0, 18'h2AAAA, 1'b0, 1'b0);
		run(1'b0, 18'h15555, 1'b0, 1'b0);
		chk_le(n_early, n);
	endtask

	// A second start while busy is ignored and flagged; entered at the exact acquisition minimum
	task automatic sc_overrun;
		int n;
		int m;
		n = n_ovr;
		m = n_early;
		run(1'b1, 18'h0F0F0, 1'b0, 1'b1);
		chk_le(n + 1, n_ovr);
		chk_le(n_ovr, n + 1);
		chk_le(n_early, m);
	endtask

	// Start right after busy falls, short of acquisition
	task automatic sc_early;
		int n;
		n = n_early;
		run(1'b1, 18'h12345, 1'b1, 1'b0);
		chk_le(n + 1, n_early);
	endtask

	// Fast mode left idle past the gap limit
	task automatic sc_stale;
		int n;
		n = n_stale;
		repeat (320) @(negedge clk);
		chk_le(n + 1, n_stale);
	endtask

	initial begin
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		sc_reset();
		sc_b2b();
		sc_overrun();
		sc_early();
		sc_stale();
		wrap_up();
	end

	initial begin
		#400000;
		n_errors++;
		$display("mismatch %0t run did not finish", $time);
		wrap_up();
	end
endmodule

`default_nettype wire

/* test/sct_host.sv */
`default_nettype none

module sct_host (
	input  wire logic                 clk_in,              // Clock
	input  wire logic                 busy_in,             // Device busy
	input  wire sct_pkg::sct_result_t res_in,              // Device result
	output logic                      convert_start_n_out, // Start, low
	output logic                      fast_out,            // Mode
	output logic [17:0]               smp_out              // Sample
);
	timeunit 1ns;
	timeprecision 1ps;
	int el;
	initial begin
		convert_start_n_out = 1'b1;
		fast_out = 1'b1;
		smp_out = 18'h00000;
		el = 100000;
	end
	// One conversion; rush skips the idle wait, poke pulses start again while busy
	task automatic conv(input logic f, input logic [17:0] v, input logic rush,
		input logic poke, output logic [17:0] got, output int nb, output int tv);
		int sp;
		int aq;
		int i;
		sp = f ? sct_pkg::SCT_FAST_SPACING_CYC : sct_pkg::SCT_NORM_SPACING_CYC;
		aq = f ? sct_pkg::SCT_FAST_ACQ_CYC : sct_pkg::SCT_NORM_ACQ_CYC;
		i = 0;
		// Exact minimum spacing and acquisition: two more edges pass before the start is seen
		while (!rush && (el < sp - 2 || i < aq - 2)) begin
			@(negedge clk_in);
			el++;
			i++;
		end
		@(negedge clk_in);
		fast_out = f;
		smp_out = v;
		convert_start_n_out = 1'b0;
		el = 0;
		nb = 0;
		tv = 0;
		@(negedge clk_in);
		convert_start_n_out = 1'b1;
		smp_out = ~v; // Input moves on after the aperture
		for (i = 1; i < 200 && busy_in === 1'b1; i++) begin
			if (res_in.valid === 1'b1 && tv == 0) tv = i;
			nb++;
			@(negedge clk_in);
			el++;
			convert_start_n_out = !(poke && i == 9);
		end
		got = res_in.data;
		fast_out = ~f;
	endtask
endmodule

`default_nettype wire

/* verilog/sct_core.sv */
`default_nettype none

module sct_core #(
	parameter int unsigned MAX_GAP_CYC = sct_pkg::SCT_FAST_MAX_GAP_CYC
) (
	input  wire logic                              clk_in,             // 250 MHz clock
	input  wire logic                              arst_n_in,          // Async reset, low
	input  wire logic                              convert_start_n_in, // Start on fall
	input  wire logic                              fast_mode_in,       // 1 fast, 0 normal
	input  wire logic [sct_pkg::SCT_RES_BITS-1:0] sample_in,          // Held input level
	output logic                                   busy_out,           // Converting
	output sct_pkg::sct_result_t                   result_out,         // Result and valid
	output sct_pkg::sct_fault_t                    fault_out           // Timing fault pulses
);

	localparam int RB     = sct_pkg::SCT_RES_BITS;
	localparam int CW     = sct_pkg::SCT_CNT_W;
	localparam int GAP_W  = $clog2(MAX_GAP_CYC + 1);
	localparam int IDX_W  = $clog2(RB);
	localparam int TAIL   = sct_pkg::SCT_TAIL_CYC;
	localparam int FAST_BUSY = sct_pkg::SCT_FAST_CONV_CYC - 1;
	localparam int NORM_BUSY = sct_pkg::SCT_NORM_CONV_CYC - 1;
	localparam logic [CW-1:0] FAST_LEN  = CW'(FAST_BUSY - TAIL);
	localparam logic [CW-1:0] NORM_LEN  = CW'(NORM_BUSY - TAIL);
	localparam logic [CW-1:0] TAIL_LEN  = CW'(TAIL);
	localparam logic [CW-1:0] ACQ_MAX   = '1;
	localparam logic [GAP_W-1:0] GAP_MAX  = GAP_W'(MAX_GAP_CYC);
	localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(MAX_GAP_CYC - 1);

	// Refuse settings the counters cannot serve
	if (MAX_GAP_CYC <= sct_pkg::SCT_NORM_SPACING_CYC) begin : g_gap_chk
		$error("MAX_GAP_CYC too small");
	end
	if (FAST_BUSY - TAIL < RB + 1 || NORM_BUSY >= 2 ** CW) begin : g_len_chk
		$error("conversion length does not fit the bit steps or counter");
	end

	typedef struct packed {
		sct_pkg::sct_state_t  state;
		logic [CW-1:0]        cnt;
		logic [IDX_W-1:0]     bit_idx;
		logic                 bit_run;
		logic [RB-1:0]        samp;
		logic [RB-1:0]        sar;
		logic                 fast;
		logic                 prev_n;
		logic [GAP_W-1:0]     gap;
		logic [CW-1:0]        acq;
		logic                 busy;
		sct_pkg::sct_result_t res;
		sct_pkg::sct_fault_t  flt;
	} sct_core_st_t;

	// Gap and acquisition start saturated so the first start is never flagged
	localparam sct_core_st_t ST_RST = '{
		state:   sct_pkg::SCT_IDLE,
		cnt:     '0,
		bit_idx: '0,
		bit_run: 1'b0,
		samp:    '0,
		sar:     '0,
		fast:    1'b0,
		prev_n:  1'b1,
		gap:     GAP_MAX,
		acq:     ACQ_MAX,
		busy:    1'b0,
		res:     '{data: sct_pkg::SCT_DATA_RST, valid: 1'b0},
		flt:     '0
	};

	logic [1:0]   rst_sync;
	logic         rst_n;
	sct_core_st_t st;
	sct_core_st_t next_st;
	logic         start_edge;
	logic         too_soon;
	logic [RB-1:0] trial;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Edge of the start strobe and controller spacing check
	// Both counters lag the elapsed cycles by one, so a start on the exact minimum passes
	assign start_edge = st.prev_n & ~convert_start_n_in;
	assign too_soon   = fast_mode_in ?
		(st.gap < GAP_W'(sct_pkg::SCT_FAST_SPACING_CYC - 1)) ||
		(st.acq < CW'(sct_pkg::SCT_FAST_ACQ_CYC - 1)) :
		(st.gap < GAP_W'(sct_pkg::SCT_NORM_SPACING_CYC - 1)) ||
		(st.acq < CW'(sct_pkg::SCT_NORM_ACQ_CYC - 1));
	assign trial = st.sar | (RB'(1) << st.bit_idx);

	// Conversion sequencer
	always_comb begin
		next_st        = st;
		next_st.prev_n = convert_start_n_in;
		next_st.flt    = '0;
		if (st.gap != GAP_MAX) begin
			next_st.gap = st.gap + GAP_W'(1);
		end
		// Fast mode cannot hold its sample past the longest gap; a start on the last cycle is in time
		if (st.fast && st.gap == GAP_LAST && !start_edge) begin
			next_st.flt.stale = 1'b1;
		end
		case (st.state)
			sct_pkg::SCT_IDLE: begin
				if (st.acq != ACQ_MAX) begin
					next_st.acq = st.acq + CW'(1);
				end
				if (start_edge) begin
					next_st.state     = sct_pkg::SCT_CONV;
					next_st.busy      = 1'b1;
					next_st.fast      = fast_mode_in;
					next_st.cnt       = fast_mode_in ? FAST_LEN : NORM_LEN;
					next_st.samp      = sample_in;
					next_st.sar       = '0;
					next_st.bit_idx   = IDX_W'(RB - 1);
					next_st.bit_run   = 1'b1;
					next_st.gap       = '0;
					next_st.res.valid = 1'b0;
					next_st.flt.early = too_soon;
				end
			end
			sct_pkg::SCT_CONV: begin
				// Starts during a conversion are dropped, not restarted
				next_st.flt.overrun = start_edge;
				if (st.bit_run) begin
					if (trial <= st.samp) begin
						next_st.sar = trial;
					end
					if (st.bit_idx == '0) begin
						next_st.bit_run = 1'b0;
					end else begin
						next_st.bit_idx = st.bit_idx - IDX_W'(1);
					end
				end
				next_st.cnt = st.cnt - CW'(1);
				if (st.cnt == CW'(1)) begin
					// Internal end of conversion: result out at once
					next_st.state     = sct_pkg::SCT_TAIL;
					next_st.cnt       = TAIL_LEN;
					next_st.res.data  = st.sar;
					next_st.res.valid = 1'b1;
				end
			end
			sct_pkg::SCT_TAIL: begin
				next_st.flt.overrun = start_edge;
				next_st.cnt = st.cnt - CW'(1);
				if (st.cnt == CW'(1)) begin
					next_st.state = sct_pkg::SCT_IDLE;
					next_st.busy  = 1'b0;
					next_st.acq   = '0;
				end
			end
			default: begin
				next_st = ST_RST;
			end
		endcase
	end

	// Single state register
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	assign busy_out   = st.busy;
	assign result_out = st.res;
	assign fault_out  = st.flt;

	// Busy width, counted only for the checks below
	logic [CW-1:0] busy_len;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			busy_len <= '0;
		end else if (busy_out) begin
			busy_len <= busy_len + CW'(1);
		end else begin
			busy_len <= '0;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n);

	sequence start_idle_s;
		start_edge && st.state == sct_pkg::SCT_IDLE;
	endsequence

	sequence eoc_s;
		$rose(result_out.valid);
	endsequence

	busy_rise_a: assert property (start_idle_s |=> busy_out)
		else $error("busy did not rise after start");
	busy_width_a: assert property ($fell(busy_out) |->
		busy_len == CW'(st.fast ? FAST_BUSY : NORM_BUSY))
		else $error("busy width wrong");
	fast_conv_a: assert property ($rose(busy_out) && st.fast |->
		##[1:FAST_BUSY] eoc_s)
		else $error("fast conversion too long");
	norm_conv_a: assert property ($rose(busy_out) && !st.fast |->
		##[1:NORM_BUSY] eoc_s)
		else $error("normal conversion too long");
	eoc_busy_hold_a: assert property (eoc_s |-> busy_out [*3])
		else $error("busy fell too soon after end of conversion");
	data_lead_a: assert property (eoc_s |-> busy_out [*5] ##1 !busy_out)
		else $error("data lead before busy fall wrong");
	result_now_a: assert property ($fell(busy_out) |->
		result_out.valid && result_out.data == st.samp)
		else $error("result not current conversion");
	overrun_flag_a: assert property (busy_out && start_edge |=>
		fault_out.overrun && busy_out && $stable(st.samp))
		else $error("start during busy not refused");
	early_flag_a: assert property (start_idle_s ##0 too_soon |=> fault_out.early)
		else $error("early start not flagged");
	stale_flag_a: assert property (st.fast && st.gap == GAP_LAST && !start_edge |=>
		fault_out.stale)
		else $error("stale fast gap not flagged");

endmodule

`default_nettype wire
